// ### common/tmic_pkg.sv
// Constants, field positions and carrier types for the timer and capture block.
// Assumes one state time equals one period of the 25 MHz system clock.
package tmic_pkg;

   // Clock and state-time figures
   localparam int CLK_PERIOD_NS = 40;
   localparam int STATE_TIME_NS = 40;
   localparam int STATE_CYCLES  =
      (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_STATES   = 8;
   localparam int TICK_CYCLES   = TICK_STATES * STATE_CYCLES;
   localparam int TICK_W        = $clog2(TICK_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // Register addresses on the plain port
   localparam logic [7:0] ADDR_CAP_MODE   = 8'h03;
   localparam logic [7:0] ADDR_TIME_WORD  = 8'h04;
   localparam logic [7:0] ADDR_CAP_STATUS = 8'h06;
   localparam logic [7:0] ADDR_INT_MASK   = 8'h08;
   localparam logic [7:0] ADDR_RT_TIMER   = 8'h0C;
   localparam logic [7:0] ADDR_EV_TIMER   = 8'h0E;
   localparam logic [7:0] ADDR_IO_CONTROL_0       = 8'h15;
   localparam logic [7:0] ADDR_IO_CONTROL_1       = 8'h16;
   localparam logic [7:0] ADDR_IO_STATUS_1       = 8'h17;

   // io_control_0 fields
   localparam int IO_CONTROL_0_EN_BASE    = 0;
   localparam int IO_CONTROL_0_EN_STRIDE  = 2;
   localparam int IO_CONTROL_0_EVCLR_SW   = 1;
   localparam int IO_CONTROL_0_EXTCLR_EN  = 3;
   localparam int IO_CONTROL_0_EXTCLR_SEL = 5;
   localparam int IO_CONTROL_0_EVCLK_SEL  = 7;

   // io_control_1 fields
   localparam int IO_CONTROL_1_RT_OVF_IE = 2;
   localparam int IO_CONTROL_1_EV_OVF_IE = 3;
   localparam int IO_CONTROL_1_PIN2_OUT  = 4;
   localparam int IO_CONTROL_1_PIN3_OUT  = 6;
   localparam int IO_CONTROL_1_QMODE     = 7;

   // io_status_1 fields
   localparam int IO_STATUS_1_SWT_W  = 4;
   localparam int IO_STATUS_1_FLAG_W = 6;

   // Reset values
   localparam logic [7:0] RST_IO_CONTROL_0     = 8'h00;
   localparam logic [7:0] RST_IO_CONTROL_1     = 8'h00;
   localparam logic [7:0] RST_CAP_MODE = 8'h00;

   // Timers
   localparam int          TIMER_W      = 16;
   localparam logic [15:0] TIMER_MAX    = 16'hFFFF;
   localparam logic [15:0] TIMER_PRESET = 16'hFFF0;

   // Capture unit
   localparam int         CAP_INPUTS  = 4;
   localparam int         QUEUE_DEPTH = 7;
   localparam int         QUEUE_CW    = 3;
   localparam logic [2:0] Q_THRESH    = 3'h6;
   localparam logic [2:0] Q_FULL      = 3'h7;
   localparam logic [2:0] PRESC_LAST  = 3'h7;

   typedef enum logic [1:0] {
      CAP_EVERY8TH_RISE = 2'h0,
      CAP_EACH_RISE     = 2'h1,
      CAP_EACH_FALL     = 2'h2,
      CAP_EACH_EDGE     = 2'h3
   } tmic_cap_mode_type;

   typedef struct packed {
      logic [TIMER_W-1:0]    stamp;
      logic [CAP_INPUTS-1:0] hit;
   } tmic_entry_type;

endpackage : tmic_pkg

// ### verilog/tmic_pin_sync.sv
// Two-flop synchroniser with edge detection for a group of pins.
// Assumes pins are asynchronous to clk; edges come from the second stage.
`timescale 1ns/1ps
module tmic_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~prev_r;
   assign fall  = ~sync_r & prev_r;

endmodule : tmic_pin_sync

// ### verilog/tmic_timers_capture.sv
// Real-time timer, event timer and four-input capture unit with its queue.
// Assumes a plain register port on clk; pins are asynchronous and are
// synchronised here. Compare-unit requests arrive on clk.
`timescale 1ns/1ps

// Summary of operation
// - Real-time timer ticks every eight states, reset-only clear
// - Writing real-time timer presets both timers
// - Event timer counts both edges of selected input
// - Event timer clears by reset, software, compare, pin
// - Timer wraps set status flags and interrupts
// - Any status access clears bits zero to five
// - Overflow interrupts gated by mask bit zero
// - Each capture input has a two-bit mode
// - Divide-by-eight prescaler cleared only by reset
// - Disabled capture inputs never enter queue
// - Entry holds timer and hit flags, eight-state transfer
// - Queue plus holding register keep eight events
// - Rising input zero interrupts even when disabled
// - Queue interrupt per load or at six entries
// - Threshold interrupt re-arms after five or fewer
// - Inputs two and three share pins with outputs
// - Status shows six entries and holding data ready
// - Read status first; time-word read pops queue
// - Status byte has event and level per input
module tmic_timers_capture
   import tmic_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic      [15:0] bus_rdata,
   input  wire logic        event_timer_clock_pin,
   input  wire logic        event_timer_clear_pin,
   input  wire logic        capture_input_zero,
   input  wire logic        capture_input_one,
   input  wire logic        capture_input_two_in,
   input  wire logic        capture_input_three_in,
   output logic             timed_output_four_out,
   output logic             timed_output_four_oe,
   output logic             timed_output_five_out,
   output logic             timed_output_five_oe,
   input  wire logic        timed_output_four_level,
   input  wire logic        timed_output_five_level,
   input  wire logic        event_timer_clear_req,
   input  wire logic [3:0]  sw_timer_flag_set,
   output logic             timer_ovf_irq,
   output logic             capture_pin0_irq,
   output logic             capture_queue_irq,
   output logic             capture_overrun
);

   // Pin synchroniser: 0..3 capture inputs, 4 clock pin, 5 clear pin
   localparam int PIN_CLK = 4;
   localparam int PIN_CLR = 5;

   logic [5:0] pin_lvl;
   logic [5:0] pin_rise;
   logic [5:0] pin_fall;

   tmic_pin_sync #(
      .W (6)
   ) u_sync (
      .clk    (clk),
      .rstn   (rstn),
      .pin_in ({event_timer_clear_pin, event_timer_clock_pin,
                capture_input_three_in, capture_input_two_in,
                capture_input_one, capture_input_zero}),
      .level  (pin_lvl),
      .rise   (pin_rise),
      .fall   (pin_fall)
   );

   // Eight-state tick divider
   logic [TICK_W-1:0] tick_cnt_r;
   logic [TICK_W-1:0] tick_cnt_nxt;
   wire               tick = (tick_cnt_r == TICK_LAST);

   assign tick_cnt_nxt = tick ? '0 : tick_cnt_r + TICK_W'(1);

   // Register decode
   wire wr_cap_mode = bus_wr && (bus_addr == ADDR_CAP_MODE);
   wire wr_int_mask = bus_wr && (bus_addr == ADDR_INT_MASK);
   wire wr_rt_timer = bus_wr && (bus_addr == ADDR_RT_TIMER);
   wire wr_io_control_0     = bus_wr && (bus_addr == ADDR_IO_CONTROL_0);
   wire wr_io_control_1     = bus_wr && (bus_addr == ADDR_IO_CONTROL_1);
   wire io_status_1_access = (bus_wr || bus_rd) && (bus_addr == ADDR_IO_STATUS_1);
   wire pop_time    = bus_rd && (bus_addr == ADDR_TIME_WORD);

   logic [7:0] io_control_0_r;
   logic [7:0] io_control_1_r;
   logic [7:0] cap_mode_r;
   logic       int_mask_r;

   // Software clear of the event timer is a strobe; the bit reads zero
   wire ev_sw_clr = wr_io_control_0 && bus_wdata[IO_CONTROL_0_EVCLR_SW];

   // Real-time timer
   logic [TIMER_W-1:0] rt_r;
   logic [TIMER_W-1:0] rt_nxt;
   wire  rt_wrap = tick && !wr_rt_timer && (rt_r == TIMER_MAX);

   assign rt_nxt = wr_rt_timer ? TIMER_PRESET :
                   tick        ? rt_r + 16'h0001 : rt_r;

   // Event timer source, clears and count
   logic [TIMER_W-1:0] ev_r;
   logic [TIMER_W-1:0] ev_nxt;
   wire  ev_edge_pin  = pin_rise[PIN_CLK] | pin_fall[PIN_CLK];
   wire  ev_edge_cap1 = pin_rise[1] | pin_fall[1];
   wire  ev_edge      = io_control_0_r[IO_CONTROL_0_EVCLK_SEL] ? ev_edge_cap1
                                               : ev_edge_pin;
   wire  ev_ext_lvl   = io_control_0_r[IO_CONTROL_0_EXTCLR_SEL] ? pin_lvl[0]
                                                : pin_lvl[PIN_CLR];
   wire  ev_ext_clr   = io_control_0_r[IO_CONTROL_0_EXTCLR_EN] && ev_ext_lvl;
   wire  ev_clr       = ev_sw_clr || event_timer_clear_req ||
                        ev_ext_clr;
   // Each synchronised edge counts once; the source keeps the rate low
   wire  ev_inc       = ev_edge && !ev_clr && !wr_rt_timer;
   wire  ev_wrap      = ev_inc && (ev_r == TIMER_MAX);

   assign ev_nxt = wr_rt_timer ? TIMER_PRESET :
                   ev_clr      ? '0 :
                   ev_inc      ? ev_r + 16'h0001 : ev_r;

   // io_status_1 sticky flags: software timers 0..3, event 4, real-time 5
   logic [IO_STATUS_1_FLAG_W-1:0] io_status_1_flags_r;
   logic [IO_STATUS_1_FLAG_W-1:0] io_status_1_flags_nxt;
   wire  [IO_STATUS_1_FLAG_W-1:0] io_status_1_set = {rt_wrap, ev_wrap,
                                       sw_timer_flag_set};

   // Set wins over the access clear
   assign io_status_1_flags_nxt = (io_status_1_access ? '0 : io_status_1_flags_r) |
                           io_status_1_set;

   wire ovf_irq_nxt = int_mask_r &&
                      ((rt_wrap && io_control_1_r[IO_CONTROL_1_RT_OVF_IE]) ||
                       (ev_wrap && io_control_1_r[IO_CONTROL_1_EV_OVF_IE]));

   // Capture event detection, one slice per input
   logic [3*CAP_INPUTS-1:0] presc_r;
   logic [3*CAP_INPUTS-1:0] presc_nxt;
   logic [CAP_INPUTS-1:0]   cap_evt;
   logic [CAP_INPUTS-1:0]   cap_hit;

   genvar gi;
   generate
      for (gi = 0; gi < CAP_INPUTS; gi++) begin : g_cap
         wire [2:0] presc = presc_r[3*gi +: 3];
         wire       eighth = pin_rise[gi] && (presc == PRESC_LAST);
         wire tmic_cap_mode_type mode =
            tmic_cap_mode_type'(cap_mode_r[2*gi +: 2]);
         // Prescaler free-runs on rising edges, cleared by reset only
         assign presc_nxt[3*gi +: 3] =
            pin_rise[gi] ? presc + 3'h1 : presc;
         always_comb begin
            case (mode)
               CAP_EVERY8TH_RISE: cap_evt[gi] = eighth;
               CAP_EACH_RISE:     cap_evt[gi] = pin_rise[gi];
               CAP_EACH_FALL:     cap_evt[gi] = pin_fall[gi];
               CAP_EACH_EDGE:     cap_evt[gi] = pin_rise[gi] | pin_fall[gi];
               default:           cap_evt[gi] = 1'b0;
            endcase
         end
         assign cap_hit[gi] = cap_evt[gi] &&
            io_control_0_r[IO_CONTROL_0_EN_BASE + IO_CONTROL_0_EN_STRIDE*gi];
      end
   endgenerate

   // Capture queue of seven entries ahead of the holding register
   tmic_entry_type        q_r   [QUEUE_DEPTH];
   tmic_entry_type        q_nxt [QUEUE_DEPTH];
   logic [QUEUE_CW-1:0]   q_cnt_r;
   logic [QUEUE_CW-1:0]   q_cnt_nxt;
   tmic_entry_type        hold_r;
   logic                  hold_vld_r;
   logic                  q6_r;

   wire tmic_entry_type new_entry = '{stamp: rt_r, hit: cap_hit};
   wire any_hit   = |cap_hit;
   wire hold_free = !hold_vld_r || pop_time;
   // Head moves to the holding register on the eight-state tick
   wire load_hold = tick && hold_free && (q_cnt_r != '0);
   wire push_ok   = any_hit && ((q_cnt_r != Q_FULL) || load_hold);
   wire overrun   = any_hit && !push_ok;
   wire [QUEUE_CW-1:0] wpos = load_hold ? q_cnt_r - 3'h1 : q_cnt_r;
   wire q6        = (q_cnt_r >= Q_THRESH);

   assign q_cnt_nxt = q_cnt_r + {2'b00, push_ok} - {2'b00, load_hold};

   genvar gj;
   generate
      for (gj = 0; gj < QUEUE_DEPTH; gj++) begin : g_q
         wire tmic_entry_type shifted =
            (load_hold && gj < QUEUE_DEPTH - 1) ?
            q_r[(gj + 1) % QUEUE_DEPTH] : q_r[gj];
         assign q_nxt[gj] = (push_ok && wpos == QUEUE_CW'(gj)) ?
                            new_entry : shifted;
      end
   endgenerate

   // Queue interrupt: each load, or rising edge of the six-entry level
   wire q_irq_nxt = io_control_1_r[IO_CONTROL_1_QMODE] ? (q6 && !q6_r)
                                       : load_hold;

   // Capture status byte: event flag low, present level high
   logic [7:0] cap_status;

   generate
      for (gi = 0; gi < CAP_INPUTS; gi++) begin : g_stat
         assign cap_status[2*gi]     = hold_r.hit[gi];
         assign cap_status[2*gi + 1] = pin_lvl[gi];
      end
   endgenerate

   wire [7:0] io_status_1_value = {hold_vld_r, q6, io_status_1_flags_r};

   // Read data selection
   logic [15:0] rd_mux;

   always_comb begin
      case (bus_addr)
         ADDR_CAP_MODE:   rd_mux = {8'h00, cap_mode_r};
         ADDR_TIME_WORD:  rd_mux = hold_r.stamp;
         ADDR_CAP_STATUS: rd_mux = {8'h00, cap_status};
         ADDR_INT_MASK:   rd_mux = {15'h0000, int_mask_r};
         ADDR_RT_TIMER:   rd_mux = rt_r;
         ADDR_EV_TIMER:   rd_mux = ev_r;
         ADDR_IO_CONTROL_0:       rd_mux = {8'h00, io_control_0_r};
         ADDR_IO_CONTROL_1:       rd_mux = {8'h00, io_control_1_r};
         ADDR_IO_STATUS_1:       rd_mux = {8'h00, io_status_1_value};
         default:         rd_mux = 16'h0000;
      endcase
   end

   // Control registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         io_control_0_r     <= RST_IO_CONTROL_0;
         io_control_1_r     <= RST_IO_CONTROL_1;
         cap_mode_r <= RST_CAP_MODE;
         int_mask_r <= 1'b0;
      end else begin
         if (wr_io_control_0)
            io_control_0_r <= bus_wdata[7:0] & ~(8'h01 << IO_CONTROL_0_EVCLR_SW);
         if (wr_io_control_1)
            io_control_1_r <= bus_wdata[7:0];
         if (wr_cap_mode)
            cap_mode_r <= bus_wdata[7:0];
         if (wr_int_mask)
            int_mask_r <= bus_wdata[0];
      end
   end

   // Timers, divider and status flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_r   <= '0;
         rt_r         <= '0;
         ev_r         <= '0;
         io_status_1_flags_r <= '0;
         presc_r      <= '0;
      end else begin
         tick_cnt_r   <= tick_cnt_nxt;
         rt_r         <= rt_nxt;
         ev_r         <= ev_nxt;
         io_status_1_flags_r <= io_status_1_flags_nxt;
         presc_r      <= presc_nxt;
      end
   end

   // Queue and holding register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q_r        <= '{default: '0};
         q_cnt_r    <= '0;
         hold_r     <= '0;
         hold_vld_r <= 1'b0;
         q6_r       <= 1'b0;
      end else begin
         q_r     <= q_nxt;
         q_cnt_r <= q_cnt_nxt;
         q6_r    <= q6;
         if (load_hold) begin
            hold_r     <= q_r[0];
            hold_vld_r <= 1'b1;
         end else if (pop_time) begin
            hold_vld_r <= 1'b0;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_rdata             <= 16'h0000;
         timer_ovf_irq         <= 1'b0;
         capture_pin0_irq      <= 1'b0;
         capture_queue_irq     <= 1'b0;
         capture_overrun       <= 1'b0;
         timed_output_four_out <= 1'b0;
         timed_output_four_oe  <= 1'b0;
         timed_output_five_out <= 1'b0;
         timed_output_five_oe  <= 1'b0;
      end else begin
         bus_rdata             <= bus_rd ? rd_mux : 16'h0000;
         timer_ovf_irq         <= ovf_irq_nxt;
         capture_pin0_irq      <= pin_rise[0];
         capture_queue_irq     <= q_irq_nxt;
         capture_overrun       <= overrun;
         timed_output_four_out <= timed_output_four_level;
         timed_output_four_oe  <= io_control_1_r[IO_CONTROL_1_PIN2_OUT];
         timed_output_five_out <= timed_output_five_level;
         timed_output_five_oe  <= io_control_1_r[IO_CONTROL_1_PIN3_OUT];
      end
   end

endmodule : tmic_timers_capture

// ### testbench/tmic_timers_capture_assertions.sv
// Port-level checker for the timer and capture block.
// Assumes the bench leaves the timers untouched between paired reads.
`timescale 1ns/1ps
module tmic_timers_capture_assertions
   import tmic_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [7:0]  bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic [15:0] bus_rdata,
   input wire logic        capture_input_zero,
   input wire logic        timed_output_four_out,
   input wire logic        timed_output_four_oe,
   input wire logic        timed_output_four_level,
   input wire logic [3:0]  sw_timer_flag_set,
   input wire logic        timer_ovf_irq,
   input wire logic        capture_pin0_irq
);
   logic       mask_r;
   logic [7:0] io_control_1_r;
   logic       ovf_en;
   // Shadow copies of the gating registers, updated at the write edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_r <= 1'b0;
         io_control_1_r <= 8'h00;
      end else if (bus_wr && bus_addr == ADDR_INT_MASK) begin
         mask_r <= bus_wdata[0];
      end else if (bus_wr && bus_addr == ADDR_IO_CONTROL_1) begin
         io_control_1_r <= bus_wdata[7:0];
      end
   end
   assign ovf_en = io_control_1_r[IO_CONTROL_1_RT_OVF_IE] | io_control_1_r[IO_CONTROL_1_EV_OVF_IE];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_rt_rate: assert property (
      (bus_rd && bus_addr == ADDR_RT_TIMER) ##8
      (bus_rd && bus_addr == ADDR_RT_TIMER) |=>
      bus_rdata == $past(bus_rdata, 8) + 16'h0001)
      else $error("real-time timer rate wrong");
   chk_rt_preset: assert property (
      (bus_wr && bus_addr == ADDR_RT_TIMER) ##1
      (bus_rd && bus_addr == ADDR_RT_TIMER) |=> bus_rdata[15:1] == 15'h7FF8)
      else $error("timer preset value wrong");
   chk_flags_clear: assert property (
      (bus_rd && bus_addr == ADDR_IO_STATUS_1 && sw_timer_flag_set == 4'h0) ##1
      (bus_rd && bus_addr == ADDR_IO_STATUS_1 && sw_timer_flag_set == 4'h0) |=>
      bus_rdata[3:0] == 4'h0) else $error("status flags not cleared");
   chk_swflag_set: assert property (
      sw_timer_flag_set[0] ##1 (bus_rd && bus_addr == ADDR_IO_STATUS_1) |=>
      bus_rdata[0]) else $error("software flag not set");
   chk_ovf_mask: assert property (
      timer_ovf_irq |-> $past(mask_r)) else $error("overflow irq unmasked");
   chk_ovf_enable: assert property (
      timer_ovf_irq |-> $past(ovf_en)) else $error("overflow irq disabled");
   chk_pin0_irq: assert property (
      $rose(capture_input_zero) |-> ##[2:5] capture_pin0_irq)
      else $error("input zero irq missing");
   chk_rdata_idle: assert property (
      !$past(bus_rd) |-> bus_rdata == 16'h0000)
      else $error("read data outside read slot");
   chk_pin2_dir: assert property (
      timed_output_four_oe == $past(io_control_1_r[IO_CONTROL_1_PIN2_OUT]) &&
      (!timed_output_four_oe ||
       timed_output_four_out == $past(timed_output_four_level)))
      else $error("shared pin two direction wrong");
endmodule : tmic_timers_capture_assertions

bind tmic_timers_capture tmic_timers_capture_assertions u_chk (.*);

// ### testbench/tmic_pin_model.sv
// External pins: pins[0] event clock, [1] clear, [5:2] capture inputs.
// Assumes the bench asks for one toggle at a time on clk.
`timescale 1ns/1ps
module tmic_pin_model (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       go,
   input  wire logic [2:0] sel,
   output logic            busy,
   output logic      [5:0] pins
);
   logic [2:0] gap_r;
   // Each toggle opens an eight-cycle quiet window; requests inside it
   // are ignored, so no pin ever moves faster than its source allows.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap_r <= 3'h0;
         pins  <= 6'h00;
      end else if (go && gap_r == 3'h0) begin
         gap_r     <= 3'h7;
         pins[sel] <= ~pins[sel];
      end else if (gap_r != 3'h0) begin
         gap_r <= gap_r - 3'h1;
      end
   end
   assign busy = (gap_r != 3'h0);
endmodule : tmic_pin_model

// ### testbench/tmic_timers_capture_tb.sv
// Self-checking bench for the timer and capture block.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tmic_timers_capture_tb;
   import tmic_pkg::*;
   logic        clk, rstn, bus_wr, bus_rd, go, busy, clr_req, lvl4, lvl5;
   logic        rd_pend, oe4, oe5, out4, out5, q_irq, p0_irq, t_irq, ovr;
   logic [7:0]  bus_addr;
   logic [15:0] bus_wdata, bus_rdata;
   logic [3:0]  swf, sf;
   logic [2:0]  sel;
   logic [5:0]  pins;
   logic [31:0] e;
   logic [31:0] exp_q[$];
   int          n_errors, check_count, n_q, n_p0, n_t, n_ovr, r;

   tmic_timers_capture u_tmic_timers_capture (
      .clk, .rstn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
      .event_timer_clock_pin(pins[0]), .event_timer_clear_pin(pins[1]),
      .capture_input_zero(pins[2]), .capture_input_one(pins[3]),
      .capture_input_two_in(oe4 ? out4 : pins[4]),
      .capture_input_three_in(oe5 ? out5 : pins[5]),
      .timed_output_four_out(out4), .timed_output_four_oe(oe4),
      .timed_output_five_out(out5), .timed_output_five_oe(oe5),
      .timed_output_four_level(lvl4), .timed_output_five_level(lvl5),
      .event_timer_clear_req(clr_req), .sw_timer_flag_set(swf),
      .timer_ovf_irq(t_irq), .capture_pin0_irq(p0_irq),
      .capture_queue_irq(q_irq), .capture_overrun(ovr));
   tmic_pin_model u_tmic_pin_model (.clk, .rstn, .go, .sel, .busy, .pins);

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      check_count++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, want);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      {bus_wr, bus_rd, bus_addr, bus_wdata} <= {2'b10, a, d};
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] x,
                     input logic [15:0] m);
      exp_q.push_back({m, x});
      {bus_wr, bus_rd, bus_addr} <= {2'b01, a};
      @(posedge clk);
   endtask : rd
   task automatic idle(input int n);
      {bus_wr, bus_rd} <= 2'b00;
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic pin_edges(input logic [2:0] s, input int n);
      {bus_wr, bus_rd} <= 2'b00;
      repeat (n) begin
         {sel, go} <= {s, 1'b1};
         @(posedge clk);
         go <= 1'b0;
         @(posedge clk);
         while (busy) @(posedge clk);
      end
   endtask : pin_edges
   task automatic drain(input int n);
      repeat (n) begin
         rd(ADDR_CAP_STATUS, 16'h0004, 16'h00FF);
         rd(ADDR_TIME_WORD, 16'h0000, 16'h0000);
         idle(9);
      end
   endtask : drain
   task automatic finish_test;
      $display("errors %0d, checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   // Monitor: compares read data in its slot and counts output pulses
   always @(posedge clk) begin
      if (rd_pend === 1'b1) begin
         e = exp_q.pop_front();
         check(bus_rdata & e[31:16], e[15:0]);
      end
      rd_pend <= bus_rd;
      n_q   += (q_irq === 1'b1);
      n_p0  += (p0_irq === 1'b1);
      n_t   += (t_irq === 1'b1);
      n_ovr += (ovr === 1'b1);
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test;
   end

   initial begin
      {clk, rstn, bus_wr, bus_rd, go, clr_req, rd_pend} = '0;
      {bus_addr, bus_wdata, swf, sel} = '0;
      void'($urandom(38));
      {lvl4, lvl5} = 2'($urandom);
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      idle(1);
      rd(ADDR_IO_CONTROL_0, 16'h0000, 16'hFFFF);
      rd(ADDR_IO_CONTROL_1, 16'h0000, 16'hFFFF);
      rd(ADDR_CAP_MODE, 16'h0000, 16'hFFFF);
      rd(8'hF0, 16'h0000, 16'hFFFF);
      rd(ADDR_RT_TIMER, 16'h0000, 16'hFFF0);
      idle(7);
      rd(ADDR_RT_TIMER, 16'h0000, 16'hFFF0);
      // Preset, wrap to zero, flag set and clear, mask off then on
      wr(ADDR_IO_CONTROL_1, 16'h0004);
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_INT_MASK, 16'(m));
         r = $urandom;
         sf = 4'(r >> 16) | 4'h1;
         wr(ADDR_RT_TIMER, r[15:0]);
         rd(ADDR_RT_TIMER, 16'hFFF0, 16'hFFFE);
         rd(ADDR_EV_TIMER, 16'hFFF0, 16'hFFF0);
         idle(136);
         swf <= sf;
         @(posedge clk);
         swf <= 4'h0;
         rd(ADDR_IO_STATUS_1, {10'h000, 2'b10, sf}, 16'h003F);
         rd(ADDR_IO_STATUS_1, 16'h0000, 16'h003F);
         idle(1);
         check(16'(n_t), 16'(m));
      end
      // Every mode code on input one, drained entry by entry
      wr(ADDR_IO_CONTROL_0, 16'h0004);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CAP_MODE, 16'(k << 2));
         r = (k == 0) ? 1 : (k == 3) ? 4 : 2;
         n_q = 0;
         pin_edges(3'h3, (k == 0) ? 16 : 4);
         idle(12);
         drain(r);
         rd(ADDR_IO_STATUS_1, 16'h0000, 16'h0080);
         idle(1);
         check(16'(n_q), 16'(r));
      end
      wr(ADDR_IO_CONTROL_0, 16'h0000);
      pin_edges(3'h3, 2);
      idle(12);
      rd(ADDR_IO_STATUS_1, 16'h0000, 16'h0080);
      // Ten events unread: two dropped, threshold irq once, then re-armed
      wr(ADDR_IO_CONTROL_0, 16'h0004);
      wr(ADDR_IO_CONTROL_1, 16'h0084);
      {n_q, n_ovr} = '0;
      pin_edges(3'h3, 10);
      idle(12);
      rd(ADDR_IO_STATUS_1, 16'h00C0, 16'h00C0);
      idle(1);
      check(16'(n_ovr), 16'h0002);
      check(16'(n_q), 16'h0001);
      drain(8);
      pin_edges(3'h3, 7);
      idle(12);
      check(16'(n_q), 16'h0002);
      // Input zero interrupts while kept out of the queue; shared pins
      n_p0 = 0;
      pin_edges(3'h2, 4);
      idle(6);
      check(16'(n_p0), 16'h0002);
      wr(ADDR_IO_CONTROL_1, 16'h0050);
      idle(2);
      check({12'h000, oe4, oe5, out4, out5},
            {12'h000, 2'b11, lvl4, lvl5});
      // Event timer: both edges, source select, clear sources
      wr(ADDR_IO_CONTROL_0, 16'h0002);
      r = 2 + $urandom % 4;
      pin_edges(3'h0, r);
      idle(2);
      rd(ADDR_EV_TIMER, 16'(r), 16'hFFFF);
      wr(ADDR_IO_CONTROL_0, 16'h0080);
      pin_edges(3'h0, 1);
      pin_edges(3'h3, 2);
      idle(2);
      rd(ADDR_EV_TIMER, 16'(r + 2), 16'hFFFF);
      wr(ADDR_IO_CONTROL_0, 16'h0088);
      pin_edges(3'h1, 1);
      idle(2);
      rd(ADDR_EV_TIMER, 16'h0000, 16'hFFFF);
      pin_edges(3'h1, 1);
      wr(ADDR_IO_CONTROL_0, 16'h0080);
      pin_edges(3'h3, 1);
      idle(2);
      clr_req <= 1'b1;
      @(posedge clk);
      clr_req <= 1'b0;
      rd(ADDR_EV_TIMER, 16'h0000, 16'hFFFF);
      // Event timer wrap raises its flag and interrupt; input 0 clears
      wr(ADDR_IO_CONTROL_1, 16'h0008);
      wr(ADDR_IO_CONTROL_0, 16'h0000);
      wr(ADDR_RT_TIMER, 16'h0000);
      pin_edges(3'h0, 16);
      idle(2);
      rd(ADDR_IO_STATUS_1, 16'h0010, 16'h0010);
      idle(1);
      check(16'(n_t), 16'h0002);
      pin_edges(3'h0, 1);
      wr(ADDR_IO_CONTROL_0, 16'h0028);
      pin_edges(3'h2, 1);
      idle(2);
      rd(ADDR_EV_TIMER, 16'h0000, 16'hFFFF);
      idle(3);
      finish_test;
   end
endmodule : tmic_timers_capture_tb
